/* hw/flash_seq_pkg.sv */
// Shared types and constants for the flash erase and program sequencer
package flash_seq_pkg;
  localparam logic [31:0] UNLOCK_KEY_FIRST = 32'h4567_0123;
  localparam logic [31:0] UNLOCK_KEY_SECOND = 32'hCDEF_89AB;
  localparam logic [31:0] MAIN_FIRST = 32'h0800_0000;
  localparam logic [31:0] MAIN_LAST = 32'h0801_FFFF;
  localparam logic [31:0] OTP_FIRST = 32'h1FFF_7000;
  localparam logic [31:0] OTP_LAST = 32'h1FFF_71FF;
  localparam logic [31:0] PAGE_MASK = 32'hFFFF_FC00;
  // Each protection bit covers four 1 KB pages
  localparam int WP_GROUP_MSB = 16;
  localparam int WP_GROUP_LSB = 12;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [2:0] HALF_BYTES = 3'h2;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_FOUR = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CHECK = 2'h1,
    ST_RUN = 2'h3
  } state_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PAGE_ERASE = 3'h1,
    OP_MASS_ERASE = 3'h2,
    OP_OPTION_ERASE = 3'h3,
    OP_BLANK_CHECK = 3'h4,
    OP_PROGRAM = 3'h5
  } flash_op_type;

  typedef struct packed {
    logic control_lock;
    logic page_erase_select;
    logic mass_erase_select;
    logic program_enable;
    logic option_erase_select;
    logic option_program_select;
    logic option_write_enable;
    logic start;
    logic end_interrupt_enable;
    logic error_interrupt_enable;
  } ctl_type;

  typedef struct packed {
    logic busy;
    logic end_of_operation_flag;
    logic write_protect_error_flag;
    logic program_error_flag;
    logic program_alignment_error_flag;
  } stat_type;

  typedef struct packed {
    logic valid;
    flash_op_type op;
    logic [31:0] addr;
    logic wide;
    logic [63:0] data;
  } flash_req_type;

  localparam ctl_type CTL_RESET = '{control_lock: 1'b1, default: 1'b0};
  localparam stat_type STAT_RESET = '0;
  localparam flash_req_type REQ_RESET = '{op: OP_NONE, default: '0};
endpackage

/* hw/flash_controller.sv */
// Flash erase/program command sequencer with key lock and write gathering
`timescale 1ns/1ps
// Function
// - page erase sets the selected page to ones, other pages untouched
// - success sets end flag; end interrupt when enabled
// - page erase on protected page refused, write-protect error raised
// - mass erase select plus start erases whole main block
// - mass erase refused if any page protected, error raised
// - program writes gather into 32 or 64 bit word by width bit
// - word writes: one for 32-bit program, two for 64-bit program
// - half writes: two for 32-bit program, four for 64-bit program
// - target blank-checked first; not erased sets program error flag
// - program write to protected page discarded, write-protect error set
// - byte-size program write sets alignment error
// - size change within a group sets alignment error
// - misaligned or foreign follow-on write sets alignment error
// - incomplete group writes nothing and raises nothing
// - program, alignment, protect errors raise error interrupt if enabled
// - one-time block programs like main flash, never erased
// - locked after reset; two keys unlock; wrong key locks, bus error
// - option key pair sets option write enable; software may clear
module flash_controller
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Key registers
  input wire logic key_wr,
  input wire logic option_key_wr,
  input wire logic [31:0] key_data,
  output logic bus_error,
  // Control, address and width configuration
  input wire logic ctl_wr,
  input wire ctl_type ctl_wdata,
  input wire logic addr_wr,
  input wire logic [31:0] addr_wdata,
  input wire logic program_width,
  input wire logic [31:0] wp_mask,
  output ctl_type flash_control_register,
  output logic [31:0] flash_address_register,
  // Status and interrupts
  input wire stat_type stat_clear,
  output stat_type flash_status_register,
  output logic end_irq,
  output logic error_irq,
  // Data bus program writes
  input wire logic data_bus_wr,
  input wire logic [1:0] data_bus_size,
  input wire logic [31:0] data_bus_addr,
  input wire logic [31:0] data_bus_wdata,
  // Flash array macro
  output flash_req_type flash_req,
  input wire logic flash_done,
  input wire logic flash_blank
);

  function automatic logic in_main(input logic [31:0] a);
    in_main = (a >= MAIN_FIRST) && (a <= MAIN_LAST);
  endfunction
  function automatic logic in_otp(input logic [31:0] a);
    in_otp = (a >= OTP_FIRST) && (a <= OTP_LAST);
  endfunction
  // Zero in the mask means the page group is protected
  function automatic logic is_protected(input logic [31:0] a,
                                        input logic [31:0] wp);
    is_protected = in_main(a) && !wp[a[WP_GROUP_MSB:WP_GROUP_LSB]];
  endfunction

  state_type state;
  ctl_type ctl;
  stat_type stat;
  logic key_stage;
  logic okey_stage;
  logic [31:0] base;
  logic [1:0] size_q;
  logic [2:0] cnt;
  logic [63:0] gather;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Key sequences
  wire key_first = key_data == UNLOCK_KEY_FIRST;
  wire key_second = key_data == UNLOCK_KEY_SECOND;
  wire key_good = key_stage ? key_second : key_first;
  wire key_bad = key_wr && !key_good;
  wire okey_good = !ctl.control_lock &&
    (okey_stage ? key_second : key_first);
  wire okey_bad = option_key_wr && !okey_good;
  wire ctl_ok = ctl_wr && !ctl.control_lock;
  // Erase command decode
  wire start_go = ctl_ok && ctl_wdata.start && !stat.busy;
  wire mass_sel = ctl_wdata.mass_erase_select;
  wire page_sel = ctl_wdata.page_erase_select && !mass_sel;
  wire opt_sel = ctl_wdata.option_erase_select && !mass_sel && !page_sel;
  wire any_sel = mass_sel || page_sel || opt_sel;
  wire mass_refuse = mass_sel && (&wp_mask) == 1'b0;
  wire page_refuse = page_sel && (!in_main(flash_address_register) ||
    is_protected(flash_address_register, wp_mask));
  wire opt_refuse = opt_sel && !ctl.option_write_enable;
  wire erase_refuse = start_go &&
    (mass_refuse || page_refuse || opt_refuse);
  wire erase_go = start_go && any_sel && !erase_refuse;
  wire flash_op_type erase_op = mass_sel ? OP_MASS_ERASE :
    (page_sel ? OP_PAGE_ERASE : OP_OPTION_ERASE);

  // Program write gathering
  wire pg_wr = data_bus_wr && ctl.program_enable && state == ST_IDLE &&
    !stat.busy;
  wire size_ok = data_bus_size == SIZE_HALF || data_bus_size == SIZE_WORD;
  wire [2:0] size_bytes = data_bus_size == SIZE_HALF ? HALF_BYTES :
    WORD_BYTES;
  wire [2:0] need = data_bus_size == SIZE_HALF ?
    (program_width ? CNT_FOUR : CNT_TWO) :
    (program_width ? CNT_TWO : CNT_ONE);
  wire [2:0] exp_off = 3'(cnt * size_bytes);
  wire unit_aligned = program_width ? data_bus_addr[2:0] == 3'h0 :
    data_bus_addr[1:0] == 2'h0;
  wire first_ok = cnt == 3'h0 && unit_aligned;
  wire next_ok = cnt != 3'h0 && data_bus_size == size_q &&
    data_bus_addr == base + {29'h0, exp_off};
  wire write_ok = pg_wr && size_ok && (first_ok || next_ok);
  wire align_err = pg_wr && !write_ok;
  wire grp_done = write_ok && 3'(cnt + CNT_ONE) == need;
  wire [31:0] tgt = cnt == 3'h0 ? data_bus_addr : base;
  wire prog_refuse = grp_done &&
    (!(in_main(tgt) || in_otp(tgt)) || is_protected(tgt, wp_mask));
  wire prog_go = grp_done && !prog_refuse;
  wire [63:0] lane = size_bytes == HALF_BYTES ? 64'h0000_0000_0000_FFFF :
    64'h0000_0000_FFFF_FFFF;
  wire [63:0] next_gather = (gather & ~(lane << {exp_off, 3'h0})) |
    (({32'h0, data_bus_wdata} & lane) << {exp_off, 3'h0});
  // Flag events
  wire set_end = state == ST_RUN && flash_done;
  wire set_program_error_flag = state == ST_CHECK && flash_done && !flash_blank;
  wire set_write_protect_error_flag = erase_refuse || prog_refuse;
  wire next_busy = stat.busy ? !(set_end || set_program_error_flag) :
    (erase_go || prog_go);
  assign flash_control_register = ctl;
  assign flash_status_register = stat;
  assign end_irq = stat.end_of_operation_flag &&
    ctl.end_interrupt_enable;
  assign error_irq = ctl.error_interrupt_enable &&
    (stat.write_protect_error_flag || stat.program_error_flag ||
     stat.program_alignment_error_flag);
  // Lock, option enable and control register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctl <= CTL_RESET;
      key_stage <= 1'b0;
      okey_stage <= 1'b0;
      bus_error <= 1'b0;
    end
    else
    begin
      bus_error <= key_bad || okey_bad;
      if (key_wr)
      begin
        key_stage <= key_good && !key_stage;
        if (key_bad)
          ctl.control_lock <= 1'b1;
        else if (key_stage)
          ctl.control_lock <= 1'b0;
      end
      else if (ctl_ok)
      begin
        ctl.control_lock <= ctl_wdata.control_lock;
        ctl.page_erase_select <= ctl_wdata.page_erase_select;
        ctl.mass_erase_select <= ctl_wdata.mass_erase_select;
        ctl.program_enable <= ctl_wdata.program_enable;
        ctl.end_interrupt_enable <= ctl_wdata.end_interrupt_enable;
        ctl.error_interrupt_enable <= ctl_wdata.error_interrupt_enable;
        if (ctl.option_write_enable)
        begin
          ctl.option_erase_select <= ctl_wdata.option_erase_select;
          ctl.option_program_select <= ctl_wdata.option_program_select;
        end
        if (!ctl_wdata.option_write_enable)
          ctl.option_write_enable <= 1'b0;
      end
      if (option_key_wr)
      begin
        okey_stage <= okey_good && !okey_stage;
        if (okey_good && okey_stage)
          ctl.option_write_enable <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      flash_address_register <= '0;
    else if (addr_wr && !stat.busy)
      flash_address_register <= addr_wdata;
  end
  // Gathering state; an unfinished group just waits
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt <= 3'h0;
      base <= '0;
      size_q <= SIZE_BYTE;
      gather <= '0;
    end
    else if (align_err || grp_done)
      cnt <= 3'h0;
    else if (write_ok)
    begin
      cnt <= 3'(cnt + CNT_ONE);
      gather <= next_gather;
      if (cnt == 3'h0)
      begin
        base <= data_bus_addr;
        size_q <= data_bus_size;
      end
    end
  end

  // Sticky status; a set in the clear cycle wins
  always_ff @(posedge mclk)
  begin
    if (rst)
      stat <= STAT_RESET;
    else
    begin
      stat.busy <= next_busy;
      stat.end_of_operation_flag <= set_end ||
        (stat.end_of_operation_flag &&
         !stat_clear.end_of_operation_flag);
      stat.write_protect_error_flag <= set_write_protect_error_flag ||
        (stat.write_protect_error_flag &&
         !stat_clear.write_protect_error_flag);
      stat.program_error_flag <= set_program_error_flag ||
        (stat.program_error_flag &&
         !stat_clear.program_error_flag);
      stat.program_alignment_error_flag <= align_err ||
        (stat.program_alignment_error_flag &&
         !stat_clear.program_alignment_error_flag);
    end
  end

  // Sequencer and flash macro request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      flash_req <= REQ_RESET;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (erase_go)
          begin
            state <= ST_RUN;
            flash_req <= '{valid: 1'b1, op: erase_op, wide: 1'b0,
              addr: flash_address_register & PAGE_MASK,
              data: '1};
          end
          else if (prog_go)
          begin
            state <= ST_CHECK;
            flash_req <= '{valid: 1'b1, op: OP_BLANK_CHECK,
              wide: program_width, addr: tgt,
              data: next_gather};
          end
        end
        ST_CHECK:
        begin
          if (flash_done)
          begin
            state <= flash_blank ? ST_RUN : ST_IDLE;
            flash_req.valid <= flash_blank;
            flash_req.op <= flash_blank ? OP_PROGRAM : OP_NONE;
          end
        end
        ST_RUN:
        begin
          if (flash_done)
          begin
            state <= ST_IDLE;
            flash_req <= REQ_RESET;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          flash_req <= REQ_RESET;
        end
      endcase
    end
  end

  property p_end_done;
    set_end |=> stat.end_of_operation_flag && !stat.busy;
  endproperty
  a_end_done: assert property (p_end_done)
    else $error("end flag or busy wrong after completion");
  property p_end_irq;
    $rose(stat.end_of_operation_flag) && ctl.end_interrupt_enable
      |-> end_irq;
  endproperty
  a_end_irq: assert property (p_end_irq)
    else $error("end interrupt missing");
  property p_mass_refuse;
    start_go && mass_sel && (&wp_mask) == 1'b0
      |=> stat.write_protect_error_flag && !stat.busy && !flash_req.valid;
  endproperty
  a_mass_refuse: assert property (p_mass_refuse)
    else $error("mass erase not refused on protected page");
  property p_page_refuse;
    start_go && page_sel && is_protected(flash_address_register, wp_mask)
      |=> stat.write_protect_error_flag && state == ST_IDLE;
  endproperty
  a_page_refuse: assert property (p_page_refuse)
    else $error("page erase not refused on protected page");
  property p_page_erase;
    erase_go && page_sel |=> flash_req.valid &&
      flash_req.op == OP_PAGE_ERASE && flash_req.addr[9:0] == 10'h000
      ##0 stat.busy;
  endproperty
  a_page_erase: assert property (p_page_erase)
    else $error("page erase request malformed");
  property p_byte_write;
    pg_wr && data_bus_size == SIZE_BYTE
      |=> stat.program_alignment_error_flag && cnt == 3'h0;
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte program write not flagged");
  property p_not_blank;
    state == ST_CHECK && flash_done && !flash_blank
      |=> stat.program_error_flag && !flash_req.valid && !stat.busy;
  endproperty
  a_not_blank: assert property (p_not_blank)
    else $error("program error not raised on used location");
  property p_partial;
    write_ok && !grp_done |=> !flash_req.valid && !stat.busy &&
      !$rose(stat.end_of_operation_flag);
  endproperty
  a_partial: assert property (p_partial)
    else $error("partial group started flash activity");
  property p_bad_key;
    key_bad |=> ctl.control_lock && bus_error ##1
      !bus_error || $past(key_wr || option_key_wr);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("wrong key did not lock or flag bus error");
  property p_prog_wp;
    prog_refuse |=> stat.write_protect_error_flag && state == ST_IDLE;
  endproperty
  a_prog_wp: assert property (p_prog_wp)
    else $error("protected program write not discarded");
endmodule

/* tb/flash_array_model.sv */
// Behavioural flash array that answers the sequencer's requests
`timescale 1ns/1ps
module flash_array_model
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Macro handshake
  input wire flash_req_type flash_req,
  output logic flash_done,
  output logic flash_blank
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] gone [$];
  logic [31:0] a;
  logic nb;
  int cnt = 0;
  int served = 0;

  // Absent words read as erased ones
  task automatic wipe(input logic [31:0] lo, input logic [31:0] hi);
    gone = {};
    foreach (mem[k])
      if (k >= lo && k <= hi)
        gone.push_back(k);
    foreach (gone[i])
      mem.delete(gone[i]);
  endtask

  initial
  begin
    flash_done = 1'b0;
    flash_blank = 1'b0;
  end

  // Latency varies 1 to 4 cycles; blank toggles when not answering
  always @(posedge mclk)
  begin
    a = flash_req.addr;
    nb = ~flash_blank;
    flash_done <= 1'b0;
    if (rst || flash_done || !flash_req.valid)
      cnt <= 0;
    else if (cnt < served % 4)
      cnt <= cnt + 1;
    else
    begin
      flash_done <= 1'b1;
      served <= served + 1;
      case (flash_req.op)
        OP_BLANK_CHECK:
          nb = !mem.exists(a) && !(flash_req.wide && mem.exists(a + 4));
        OP_PROGRAM:
        begin
          mem[a] = flash_req.data[31:0];
          if (flash_req.wide)
            mem[a + 4] = flash_req.data[63:32];
        end
        OP_PAGE_ERASE:
          wipe(a & PAGE_MASK, (a & PAGE_MASK) | 32'h3FF);
        OP_MASS_ERASE:
          wipe(MAIN_FIRST, MAIN_LAST);
        default:
          nb = nb;
      endcase
    end
    flash_blank <= nb;
  end
  // Nothing reads the array mid-operation
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the flash erase and program sequencer
`timescale 1ns/1ps
module tb_top
  import flash_seq_pkg::*;
;
  logic mclk = 0;
  logic rst = 1;
  logic key_wr = 0, option_key_wr = 0, ctl_wr = 0, addr_wr = 0;
  logic program_width = 0, data_bus_wr = 0, ie = 1, owe = 0;
  logic bus_error, end_irq, error_irq, flash_done, flash_blank;
  logic [31:0] key_data = '0, addr_wdata = '0, wp_mask = '1;
  logic [31:0] data_bus_addr = '0, data_bus_wdata = '0;
  logic [31:0] flash_address_register, base;
  logic [1:0] data_bus_size = 2'h2;
  logic [63:0] d;
  ctl_type ctl_wdata = '0, flash_control_register;
  stat_type stat_clear = '0, flash_status_register, exp_st = '0;
  flash_req_type flash_req;
  logic [31:0] exp_mem [logic [31:0]];
  int seed = 51398;
  int bad_count = 0, compares = 0, c, n;

  always #2.5 mclk = ~mclk;

  flash_controller dut (.mclk(mclk), .rst(rst), .key_wr(key_wr),
    .option_key_wr(option_key_wr), .key_data(key_data),
    .bus_error(bus_error), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .addr_wr(addr_wr), .addr_wdata(addr_wdata),
    .program_width(program_width), .wp_mask(wp_mask),
    .flash_control_register(flash_control_register),
    .flash_address_register(flash_address_register),
    .stat_clear(stat_clear), .flash_status_register(flash_status_register),
    .end_irq(end_irq), .error_irq(error_irq), .data_bus_wr(data_bus_wr),
    .data_bus_size(data_bus_size), .data_bus_addr(data_bus_addr),
    .data_bus_wdata(data_bus_wdata), .flash_req(flash_req),
    .flash_done(flash_done), .flash_blank(flash_blank));

  flash_array_model far_end (.mclk(mclk), .rst(rst), .flash_req(flash_req),
    .flash_done(flash_done), .flash_blank(flash_blank));

  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what,
               got, exp);
    end
  endtask

  task automatic key(input logic opt, input logic [31:0] v);
    tick();
    key_wr = !opt;
    option_key_wr = opt;
    key_data = v;
    tick();
    key_wr = 0;
    option_key_wr = 0;
  endtask

  // Fields: page, mass, program, option erase, start
  task automatic ctl(input logic [4:0] f);
    ctl_wdata = '{1'b0, f[4], f[3], f[2], f[1], 1'b0, owe, f[0], ie, ie};
    ctl_wr = 1;
    tick();
    ctl_wr = 0;
  endtask

  task automatic setaddr(input logic [31:0] a);
    addr_wdata = a;
    addr_wr = 1;
    tick();
    addr_wr = 0;
  endtask

  task automatic group(input logic [1:0] sz, input logic [31:0] a,
                       input logic [63:0] v, input int cnt);
    int s;
    tick();
    s = (sz == SIZE_HALF) ? 2 : 4;
    for (int i = 0; i < cnt; i++)
    begin
      data_bus_wr = 1;
      data_bus_size = sz;
      data_bus_addr = a + s * i;
      data_bus_wdata = 32'(v >> (8 * s * i));
      tick();
    end
    data_bus_wr = 0;
  endtask

  function automatic void exp_prog(input logic [31:0] a,
                                   input logic [63:0] v, input logic w);
    if (exp_mem.exists(a) || (w && exp_mem.exists(a + 4)))
      exp_st.program_error_flag = 1;
    else
    begin
      exp_mem[a] = v[31:0];
      if (w)
        exp_mem[a + 4] = v[63:32];
      exp_st.end_of_operation_flag = 1;
    end
  endfunction

  function automatic void exp_erase(input logic [31:0] lo,
                                    input logic [31:0] hi);
    logic [31:0] q [$];
    foreach (exp_mem[k])
      if (k >= lo && k <= hi)
        q.push_back(k);
    foreach (q[i])
      exp_mem.delete(q[i]);
    exp_st.end_of_operation_flag = 1;
  endfunction

  // Mode 0: never busy, 1: must go busy, 2: either
  task automatic finish_op(input int mode, input string name);
    logic seen;
    seen = 0;
    for (int i = 0; i < 400; i++)
    begin
      tick();
      seen = seen | flash_status_register.busy;
      if (i > 2 && flash_status_register.busy === 1'b0)
        break;
    end
    if (mode < 2)
      chk(seen, mode, "busy seen");
    chk(flash_status_register, exp_st, "status");
    chk(end_irq, exp_st.end_of_operation_flag & ie, "end irq");
    chk(error_irq, ie & |exp_st[2:0], "error irq");
    chk(far_end.mem.num(), exp_mem.num(), "word count");
    foreach (exp_mem[k])
      chk(far_end.mem.exists(k) ? far_end.mem[k] : 32'hFFFF_FFFF,
          exp_mem[k], "stored word");
    exp_st = '0;
    stat_clear = '1;
    tick();
    stat_clear = '0;
    $display("test %s done", name);
  endtask

  initial
  begin
    repeat (6) tick();
    rst = 0;
    chk(flash_control_register, CTL_RESET, "ctl reset");
    chk(flash_status_register, STAT_RESET, "stat reset");
    ctl(5'h04);
    tick();
    chk(flash_control_register, CTL_RESET, "locked write");
    for (c = 0; c < 2; c++)
    begin
      key(0, UNLOCK_KEY_FIRST);
      key(0, UNLOCK_KEY_SECOND);
      tick();
      chk(flash_control_register.control_lock, 0, "unlock");
      if (c == 0)
      begin
        key(0, 32'h0BAD_0BAD);
        n = (bus_error === 1'b1);
        tick();
        n += (bus_error === 1'b1);
        tick();
        n += (bus_error === 1'b1);
        chk(n, 1, "bus error pulse");
        chk(flash_control_register.control_lock, 1, "relock");
      end
    end
    $display("test key lock done");
    ctl(5'h04);
    for (c = 0; c < 4; c++)
    begin
      program_width = c[1];
      base = MAIN_FIRST + 32'h1000 + 32'h400 * c + ($random(seed) & 32'h3F8);
      d = {$random(seed), $random(seed)};
      n = (c[1] ? 8 : 4) / (c[0] ? 2 : 4);
      group(c[0] ? SIZE_HALF : SIZE_WORD, base, d, n);
      exp_prog(base, d, c[1]);
      finish_op(1, "program");
    end
    group(SIZE_HALF, base, 64'h0, 4);
    exp_prog(base, 64'h0, 1);
    finish_op(1, "reprogram zero");
    base = MAIN_FIRST + 32'h2000;
    group(SIZE_WORD, base, d, 1);
    repeat (10) tick();
    chk(flash_status_register, STAT_RESET, "partial group");
    chk(flash_req.valid, 0, "partial group idle");
    group(SIZE_WORD, base + 4, d >> 32, 1);
    exp_prog(base, d, 1);
    finish_op(1, "partial then complete");
    base = MAIN_FIRST + 32'h2100;
    for (c = 0; c < 4; c++)
    begin
      group(c == 0 ? SIZE_BYTE : SIZE_WORD, base + (c == 3 ? 4 : 0), d, 1);
      if (c == 1)
        group(SIZE_HALF, base + 4, d, 1);
      if (c == 2)
        group(SIZE_WORD, base + 8, d, 1);
      exp_st.program_alignment_error_flag = 1;
      finish_op(0, "alignment");
    end
    wp_mask = 32'hFFFF_FFFE;
    group(SIZE_WORD, MAIN_FIRST + 32'h10, d, 2);
    exp_st.write_protect_error_flag = 1;
    finish_op(2, "protected program");
    ctl(5'h10);
    setaddr(MAIN_FIRST);
    chk(flash_address_register, MAIN_FIRST, "addr reg");
    ctl(5'h11);
    exp_st.write_protect_error_flag = 1;
    finish_op(0, "protected page erase");
    ie = 0;
    ctl(5'h09);
    exp_st.write_protect_error_flag = 1;
    finish_op(0, "protected mass erase");
    ie = 1;
    wp_mask = '1;
    ctl(5'h10);
    setaddr(32'h0800_1400 | ($random(seed) & 32'h3FC));
    ctl(5'h11);
    exp_erase(32'h0800_1400, 32'h0800_17FF);
    finish_op(1, "page erase");
    program_width = 0;
    ctl(5'h04);
    for (c = 0; c < 2; c++)
    begin
      group(SIZE_WORD, OTP_FIRST + 32'h20, c ? 64'h0 : d, 1);
      exp_prog(OTP_FIRST + 32'h20, c ? 64'h0 : d, 0);
      finish_op(1, "otp program");
    end
    ctl(5'h09);
    exp_erase(MAIN_FIRST, MAIN_LAST);
    finish_op(1, "mass erase");
    ctl(5'h03);
    exp_st.write_protect_error_flag = 1;
    finish_op(0, "option erase locked");
    key(1, UNLOCK_KEY_FIRST);
    key(1, UNLOCK_KEY_SECOND);
    tick();
    chk(flash_control_register.option_write_enable, 1, "opt key");
    owe = 1;
    ctl(5'h03);
    exp_st.end_of_operation_flag = 1;
    finish_op(1, "option erase");
    owe = 0;
    ctl(5'h00);
    tick();
    chk(flash_control_register.option_write_enable, 0, "opt clr");
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
